// [common/pes_pkg.sv]
// Constants shared by the performance event selector
package pes_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PORT_N = 6;
    localparam int UOP_W = 3;
    localparam int RET_W = 3;
    localparam int RAW_W = 6;
    localparam int COUNT_W = 48;

    // ----------------------------------------------------------------
    // Event numbers
    // ----------------------------------------------------------------
    localparam logic [7:0] EV_UOPS_EXEC = 8'hb1;
    localparam logic [7:0] EV_SUPER_QUEUE = 8'hb2;
    localparam logic [7:0] EV_SNOOP = 8'hb8;
    localparam logic [7:0] EV_RETIRED = 8'hc0;

    // ----------------------------------------------------------------
    // Unit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] UM_PORT0 = 8'h01;
    localparam logic [7:0] UM_PORT1 = 8'h02;
    localparam logic [7:0] UM_PORT2 = 8'h04;
    localparam logic [7:0] UM_PORT3 = 8'h08;
    localparam logic [7:0] UM_PORT4 = 8'h10;
    localparam logic [7:0] UM_NO_PORT5 = 8'h1f;
    localparam logic [7:0] UM_PORT5 = 8'h20;
    localparam logic [7:0] UM_ANY_PORT = 8'h3f;
    localparam logic [7:0] UM_PORT015 = 8'h40;
    localparam logic [7:0] UM_PORT234 = 8'h80;
    localparam logic [7:0] UM_SUPER_QUEUE_FULL = 8'h01;
    localparam logic [7:0] UM_SNOOP_HIT = 8'h01;
    localparam logic [7:0] UM_SNOOP_HITE = 8'h02;
    localparam logic [7:0] UM_SNOOP_HITM = 8'h04;
    localparam logic [7:0] UM_RET_ANY = 8'h00;
    localparam logic [7:0] UM_RET_MMX = 8'h02;

    // ----------------------------------------------------------------
    // Port membership per mask, bit i is port i
    // ----------------------------------------------------------------
    localparam logic [5:0] PM_NONE = 6'h00;
    localparam logic [5:0] PM_PORT0 = 6'h01;
    localparam logic [5:0] PM_PORT1 = 6'h02;
    localparam logic [5:0] PM_PORT2 = 6'h04;
    localparam logic [5:0] PM_PORT3 = 6'h08;
    localparam logic [5:0] PM_PORT4 = 6'h10;
    localparam logic [5:0] PM_PORT5 = 6'h20;
    localparam logic [5:0] PM_NO_PORT5 = 6'h1f;
    localparam logic [5:0] PM_ANY_PORT = 6'h3f;
    localparam logic [5:0] PM_PORT015 = 6'h23;
    localparam logic [5:0] PM_PORT234 = 6'h1c;
    localparam logic [5:0] PM_CORE_ONLY = 6'h1c;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [COUNT_W-1:0] RST_COUNT = 48'h0;
    localparam logic [RAW_W-1:0] RST_INCREMENT = 6'h00;
    localparam logic RST_DECODED = 1'b0;
    localparam logic RST_PREV_COND = 1'b0;

endpackage

// [verif/pes_event_source.sv]
// Behavioural model of the pipeline event sources
module pes_event_source (
    // Execution port counts
    output logic [pes_pkg::PORT_N*pes_pkg::UOP_W-1:0] thread_uops_out,
    output logic [pes_pkg::PORT_N*pes_pkg::UOP_W-1:0] core_uops_out,
    // Other sources
    output logic super_queue_full_out,
    output logic snoop_hit_out,
    output logic snoop_hite_out,
    output logic snoop_hitm_out,
    output logic [pes_pkg::RET_W-1:0] retired_out,
    output logic [pes_pkg::RET_W-1:0] excluded_out,
    output logic [pes_pkg::RET_W-1:0] mmx_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Busy pipeline: port i runs i+1 thread uops, 7 core-wide
    task automatic drive(input logic sq);
        begin
            thread_uops_out = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
            core_uops_out = {6{3'h7}};
            super_queue_full_out = sq;
            snoop_hit_out = 1'b1;
            snoop_hite_out = 1'b0;
            snoop_hitm_out = 1'b1;
            retired_out = 3'h5;
            // Full super queue also makes every retirement a fault
            excluded_out = sq ? 3'h5 : 3'h2;
            mmx_out = 3'h4;
        end
    endtask

    // Quiet pipeline: no events at all
    task automatic idle();
        begin
            thread_uops_out = '0;
            core_uops_out = '0;
            super_queue_full_out = 1'b0;
            snoop_hit_out = 1'b0;
            snoop_hite_out = 1'b0;
            snoop_hitm_out = 1'b0;
            retired_out = 3'h0;
            excluded_out = 3'h0;
            mmx_out = 3'h0;
        end
    endtask

    initial
    begin
        idle();
    end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the performance event selector
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic enable_in = 1'b0;
    logic any_thread_in = 1'b0;
    logic [7:0] event_num_in = 8'h00;
    logic [7:0] unit_mask_in = 8'h00;
    logic [7:0] cmask_in = 8'h00;
    logic invert_in = 1'b0;
    logic edge_in = 1'b0;
    logic counter_clear_in = 1'b0;
    logic arch_retire_unsupported_in = 1'b0;
    logic [17:0] thr;
    logic [17:0] cor;
    logic sqf, hit, hite, hitm;
    logic [2:0] ret, exc, mmx;
    logic decoded_out;
    logic [5:0] increment_out;
    logic [47:0] count_out;
    int fail_count = 0;
    int compares = 0;
    int case_no = 0;

    always #2.5 clk_in = ~clk_in;

    pes_event_source src_u (
        .thread_uops_out(thr), .core_uops_out(cor),
        .super_queue_full_out(sqf), .snoop_hit_out(hit),
        .snoop_hite_out(hite), .snoop_hitm_out(hitm),
        .retired_out(ret), .excluded_out(exc), .mmx_out(mmx)
    );

    pes_event_select dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .enable_in(enable_in),
        .any_thread_in(any_thread_in), .event_num_in(event_num_in),
        .unit_mask_in(unit_mask_in), .cmask_in(cmask_in),
        .invert_in(invert_in), .edge_in(edge_in),
        .counter_clear_in(counter_clear_in),
        .arch_retire_unsupported_in(arch_retire_unsupported_in),
        .thread_uops_in(thr), .core_uops_in(cor),
        .super_queue_full_in(sqf), .snoop_hit_in(hit),
        .snoop_hite_in(hite), .snoop_hitm_in(hitm),
        .retired_instruction_count_in(ret),
        .retire_fault_excluded_in(exc), .retired_mmx_count_in(mmx),
        .decoded_out(decoded_out), .increment_out(increment_out),
        .count_out(count_out)
    );

    task automatic check(input string name, input logic [47:0] seen,
        input logic [47:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                fail_count++;
                $display("wrong value %s expected %0h seen %0h", name, exp,
                    seen);
            end
        end
    endtask

    task automatic summarize();
        begin
            $display("compares %0d fail_count %0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // Flags: dec, any_thread, unsupported, edge, invert
    // Clear, run three busy cycles, go quiet, then read the count
    task automatic do_case(input logic [7:0] ev, input logic [7:0] um,
        input logic [7:0] cm, input logic [4:0] fl, input logic sq,
        input logic [47:0] exp);
        begin
            @(posedge clk_in);
            #1;
            counter_clear_in = 1'b1;
            event_num_in = ev;
            unit_mask_in = um;
            cmask_in = cm;
            invert_in = fl[0];
            edge_in = fl[1];
            arch_retire_unsupported_in = fl[2];
            any_thread_in = fl[3];
            @(posedge clk_in);
            #1;
            counter_clear_in = 1'b0;
            enable_in = 1'b1;
            src_u.drive(sq);
            repeat (3) @(posedge clk_in);
            #1;
            check("decoded", {47'h0, decoded_out}, {47'h0, fl[4]});
            // Three like busy cycles, so the last one adds a third
            check("increment", {42'h0, increment_out}, exp / 48'd3);
            enable_in = 1'b0;
            src_u.idle();
            repeat (4) @(posedge clk_in);
            #1;
            check("count", count_out, exp);
            case_no++;
            $display("case %0d done", case_no);
        end
    endtask

    initial
    begin
        #10000;
        fail_count++;
        summarize();
    end

    initial
    begin
        repeat (3) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        do_case(8'hb1, 8'h02, 8'h00, 5'h10, 1'b0, 48'h6);
        do_case(8'hb1, 8'h02, 8'h00, 5'h18, 1'b0, 48'h15);
        do_case(8'hb1, 8'h04, 8'h00, 5'h10, 1'b0, 48'h15);
        do_case(8'hb1, 8'h08, 8'h00, 5'h10, 1'b0, 48'h15);
        do_case(8'hb1, 8'h10, 8'h00, 5'h10, 1'b0, 48'h15);
        do_case(8'hb1, 8'h1f, 8'h00, 5'h10, 1'b0, 48'h48);
        do_case(8'hb1, 8'h1f, 8'h01, 5'h10, 1'b0, 48'h3);
        do_case(8'hb1, 8'h1f, 8'h18, 5'h10, 1'b0, 48'h3);
        do_case(8'hb1, 8'h1f, 8'h19, 5'h10, 1'b0, 48'h0);
        do_case(8'hb1, 8'h20, 8'h00, 5'h10, 1'b0, 48'h12);
        do_case(8'hb1, 8'h3f, 8'h00, 5'h10, 1'b0, 48'h5a);
        do_case(8'hb1, 8'h40, 8'h00, 5'h10, 1'b0, 48'h1b);
        do_case(8'hb1, 8'h80, 8'h00, 5'h10, 1'b0, 48'h3f);
        do_case(8'hb2, 8'h01, 8'h00, 5'h10, 1'b1, 48'h3);
        do_case(8'hb2, 8'h01, 8'h01, 5'h11, 1'b0, 48'h3);
        do_case(8'hb2, 8'h01, 8'h01, 5'h13, 1'b0, 48'h1);
        do_case(8'hb1, 8'h20, 8'h01, 5'h11, 1'b0, 48'h0);
        do_case(8'hb8, 8'h01, 8'h00, 5'h10, 1'b0, 48'h3);
        do_case(8'hb8, 8'h02, 8'h00, 5'h10, 1'b0, 48'h0);
        do_case(8'hb8, 8'h04, 8'h00, 5'h10, 1'b0, 48'h3);
        do_case(8'hb8, 8'h03, 8'h00, 5'h00, 1'b0, 48'h0);
        do_case(8'hb3, 8'h02, 8'h00, 5'h00, 1'b0, 48'h0);
        do_case(8'hc0, 8'h00, 8'h00, 5'h10, 1'b0, 48'h9);
        do_case(8'hc0, 8'h00, 8'h00, 5'h04, 1'b0, 48'h0);
        do_case(8'hc0, 8'h02, 8'h00, 5'h10, 1'b0, 48'hc);
        do_case(8'hc0, 8'h00, 8'h00, 5'h10, 1'b1, 48'h0);
        do_case(8'hb1, 8'h1f, 8'h00, 5'h18, 1'b0, 48'h69);
        do_case(8'hb1, 8'h20, 8'h00, 5'h18, 1'b0, 48'h15);
        do_case(8'hb1, 8'h3f, 8'h00, 5'h18, 1'b0, 48'h7e);
        do_case(8'hb1, 8'h40, 8'h00, 5'h18, 1'b0, 48'h3f);
        do_case(8'hb1, 8'h80, 8'h00, 5'h18, 1'b0, 48'h3f);
        summarize();
    end
endmodule

// [verilog/pes_event_select.sv]
// Event decode and counter for one programmable performance counter
module pes_event_select #(
    parameter int UOP_W = pes_pkg::UOP_W,
    parameter int RET_W = pes_pkg::RET_W,
    parameter int RAW_W = pes_pkg::RAW_W,
    parameter int COUNT_W = pes_pkg::COUNT_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Selector configuration
    input wire logic enable_in,
    input wire logic any_thread_in,
    input wire logic [7:0] event_num_in,
    input wire logic [7:0] unit_mask_in,
    input wire logic [7:0] cmask_in,
    input wire logic invert_in,
    input wire logic edge_in,
    input wire logic counter_clear_in,
    input wire logic arch_retire_unsupported_in,
    // Execution port micro-op counts, port i in slice i
    input wire logic [pes_pkg::PORT_N*UOP_W-1:0] thread_uops_in,
    input wire logic [pes_pkg::PORT_N*UOP_W-1:0] core_uops_in,
    // Other event sources
    input wire logic super_queue_full_in,
    input wire logic snoop_hit_in,
    input wire logic snoop_hite_in,
    input wire logic snoop_hitm_in,
    input wire logic [RET_W-1:0] retired_instruction_count_in,
    input wire logic [RET_W-1:0] retire_fault_excluded_in,
    input wire logic [RET_W-1:0] retired_mmx_count_in,
    // Counter state
    output logic decoded_out,
    output logic [RAW_W-1:0] increment_out,
    output logic [COUNT_W-1:0] count_out
);

    localparam int PORT_N = pes_pkg::PORT_N;

    generate
        if (UOP_W < 1 || RAW_W < UOP_W + 3 || RAW_W < RET_W
            || COUNT_W < RAW_W)
        begin : g_bad_width
            $error("pes_event_select: widths cannot hold the sums");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Execution port decode
    // ----------------------------------------------------------------
    wire logic is_uops = event_num_in == pes_pkg::EV_UOPS_EXEC;
    wire logic [5:0] port_member =
        !is_uops ? pes_pkg::PM_NONE :
        unit_mask_in == pes_pkg::UM_PORT0 ? pes_pkg::PM_PORT0 :
        unit_mask_in == pes_pkg::UM_PORT1 ? pes_pkg::PM_PORT1 :
        unit_mask_in == pes_pkg::UM_PORT2 ? pes_pkg::PM_PORT2 :
        unit_mask_in == pes_pkg::UM_PORT3 ? pes_pkg::PM_PORT3 :
        unit_mask_in == pes_pkg::UM_PORT4 ? pes_pkg::PM_PORT4 :
        unit_mask_in == pes_pkg::UM_NO_PORT5 ? pes_pkg::PM_NO_PORT5 :
        unit_mask_in == pes_pkg::UM_PORT5 ? pes_pkg::PM_PORT5 :
        unit_mask_in == pes_pkg::UM_ANY_PORT ? pes_pkg::PM_ANY_PORT :
        unit_mask_in == pes_pkg::UM_PORT015 ? pes_pkg::PM_PORT015 :
        unit_mask_in == pes_pkg::UM_PORT234 ? pes_pkg::PM_PORT234 :
        pes_pkg::PM_NONE;
    wire logic uops_decoded = port_member != pes_pkg::PM_NONE;

    // Ports 2 to 4 have no per-thread view, so always use the core count
    logic [RAW_W-1:0] port_sum [0:PORT_N];
    logic [UOP_W-1:0] port_cnt [0:PORT_N-1];
    assign port_sum[0] = '0;

    genvar gi;
    generate
        for (gi = 0; gi < PORT_N; gi++)
        begin : g_port
            assign port_cnt[gi] =
                (any_thread_in || pes_pkg::PM_CORE_ONLY[gi]) ?
                core_uops_in[gi*UOP_W +: UOP_W] :
                thread_uops_in[gi*UOP_W +: UOP_W];
            assign port_sum[gi+1] = port_sum[gi]
                + (port_member[gi] ? RAW_W'(port_cnt[gi]) : RAW_W'(0));
        end
    endgenerate

    // ----------------------------------------------------------------
    // Super queue and snoop decode
    // ----------------------------------------------------------------
    wire logic sq_decoded = event_num_in == pes_pkg::EV_SUPER_QUEUE
        && unit_mask_in == pes_pkg::UM_SUPER_QUEUE_FULL;

    wire logic is_snoop = event_num_in == pes_pkg::EV_SNOOP;
    wire logic snoop_sel_hit = unit_mask_in == pes_pkg::UM_SNOOP_HIT;
    wire logic snoop_sel_hite = unit_mask_in == pes_pkg::UM_SNOOP_HITE;
    wire logic snoop_sel_hitm = unit_mask_in == pes_pkg::UM_SNOOP_HITM;
    wire logic snoop_decoded = is_snoop
        && (snoop_sel_hit || snoop_sel_hite || snoop_sel_hitm);
    wire logic snoop_event = (snoop_sel_hit & snoop_hit_in)
        | (snoop_sel_hite & snoop_hite_in)
        | (snoop_sel_hitm & snoop_hitm_in);

    // ----------------------------------------------------------------
    // Retirement decode
    // ----------------------------------------------------------------
    wire logic is_retired = event_num_in == pes_pkg::EV_RETIRED;
    wire logic ret_any_decoded = is_retired
        && unit_mask_in == pes_pkg::UM_RET_ANY
        && !arch_retire_unsupported_in;
    wire logic ret_mmx_decoded = is_retired
        && unit_mask_in == pes_pkg::UM_RET_MMX;
    // Faulting special instructions are taken out, never below zero
    wire logic [RET_W-1:0] ret_net =
        retired_instruction_count_in > retire_fault_excluded_in ?
        retired_instruction_count_in - retire_fault_excluded_in :
        RET_W'(0);

    // ----------------------------------------------------------------
    // Event value select
    // ----------------------------------------------------------------
    wire logic decoded = uops_decoded | sq_decoded | snoop_decoded
        | ret_any_decoded | ret_mmx_decoded;
    wire logic active = enable_in & decoded;
    wire logic [RAW_W-1:0] raw_event =
        uops_decoded ? port_sum[PORT_N] :
        sq_decoded ? RAW_W'(super_queue_full_in) :
        snoop_decoded ? RAW_W'(snoop_event) :
        ret_any_decoded ? RAW_W'(ret_net) :
        ret_mmx_decoded ? RAW_W'(retired_mmx_count_in) :
        RAW_W'(0);

    pes_qualifier #(
        .RAW_W(RAW_W)
    ) u_qualifier (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .active_in(active),
        .raw_in(raw_event),
        .cmask_in(cmask_in),
        .invert_in(invert_in),
        .edge_in(edge_in),
        .increment_out(increment_out)
    );

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Clear takes the counter to zero and drops that cycle's increment
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            count_out <= pes_pkg::RST_COUNT;
            decoded_out <= pes_pkg::RST_DECODED;
        end
        else
        begin
            decoded_out <= active;
            if (counter_clear_in)
                count_out <= pes_pkg::RST_COUNT;
            else
                count_out <= count_out + COUNT_W'(increment_out);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    wire logic plain = enable_in && cmask_in == 8'h00 && !invert_in
        && !edge_in;
    wire logic [RAW_W-1:0] core_sum_all =
        RAW_W'(core_uops_in[0 +: UOP_W]) + RAW_W'(core_uops_in[3 +: UOP_W])
        + RAW_W'(core_uops_in[6 +: UOP_W]) + RAW_W'(core_uops_in[9 +: UOP_W])
        + RAW_W'(core_uops_in[12 +: UOP_W]);
    wire logic [RAW_W-1:0] core_p5 = RAW_W'(core_uops_in[15 +: UOP_W]);

    AST_PORT1_THREAD: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_uops && unit_mask_in == 8'h02 && !any_thread_in
        |=> increment_out == RAW_W'($past(thread_uops_in[3 +: UOP_W])))
        else $error("port 1 count wrong");

    AST_PORT2_CORE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_uops && unit_mask_in == 8'h04
        |=> increment_out == RAW_W'($past(core_uops_in[6 +: UOP_W])))
        else $error("port 2 count is not core-wide");

    AST_PORT3_CORE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_uops && unit_mask_in == 8'h08
        |=> increment_out == RAW_W'($past(core_uops_in[9 +: UOP_W])))
        else $error("port 3 count is not core-wide");

    AST_PORT4_CORE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_uops && unit_mask_in == 8'h10
        |=> increment_out == RAW_W'($past(core_uops_in[12 +: UOP_W])))
        else $error("port 4 count is not core-wide");

    AST_NO_PORT5: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && any_thread_in && is_uops && unit_mask_in == 8'h1f
        |=> increment_out == $past(core_sum_all))
        else $error("ports 0 to 4 sum wrong");

    AST_PORT5: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && any_thread_in && is_uops && unit_mask_in == 8'h20
        |=> increment_out == $past(core_p5))
        else $error("port 5 count wrong");

    AST_ANY_PORT: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && any_thread_in && is_uops && unit_mask_in == 8'h3f
        |=> increment_out == $past(core_sum_all) + $past(core_p5))
        else $error("all ports sum wrong");

    AST_PORT015: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && any_thread_in && is_uops && unit_mask_in == 8'h40
        |=> increment_out == RAW_W'($past(core_uops_in[0 +: UOP_W]))
            + RAW_W'($past(core_uops_in[3 +: UOP_W])) + $past(core_p5))
        else $error("ports 0 1 5 sum wrong");

    AST_PORT234: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && any_thread_in && is_uops && unit_mask_in == 8'h80
        |=> increment_out == $past(core_sum_all)
            - RAW_W'($past(core_uops_in[0 +: UOP_W]))
            - RAW_W'($past(core_uops_in[3 +: UOP_W])))
        else $error("ports 2 3 4 sum wrong");

    AST_SQ_FULL: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (plain && event_num_in == 8'hb2 && unit_mask_in == 8'h01
         && super_queue_full_in) [*2]
        |=> increment_out == RAW_W'(1) && $past(increment_out) == RAW_W'(1))
        else $error("super queue full cycles missed");

    AST_SNOOP_HITM: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_snoop && unit_mask_in == 8'h04
        |=> increment_out == RAW_W'($past(snoop_hitm_in)))
        else $error("hit-modified snoop count wrong");

    AST_RET_UNSUPPORTED: assert property (@(posedge clk_in)
        disable iff (rst_in)
        is_retired && unit_mask_in == 8'h00 && arch_retire_unsupported_in
        |=> increment_out == '0 && !decoded_out)
        else $error("retired count while unsupported");

    AST_RET_FAULT: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && ret_any_decoded
        && retired_instruction_count_in <= retire_fault_excluded_in
        |=> increment_out == '0)
        else $error("faulting instructions were counted");

    AST_RET_MMX: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_retired && unit_mask_in == 8'h02
        |=> increment_out == RAW_W'($past(retired_mmx_count_in)))
        else $error("multimedia retire count wrong");

    AST_UNDECODED_HOLD: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !decoded && !counter_clear_in ##1 !counter_clear_in
        |=> $stable(count_out))
        else $error("counter moved on an undecoded selection");

    AST_PORT1_CORE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_uops && unit_mask_in == 8'h02 && any_thread_in
        |=> increment_out == RAW_W'($past(core_uops_in[3 +: UOP_W])))
        else $error("core-wide port 1 count wrong");

    AST_SNOOP_HIT: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_snoop && unit_mask_in == 8'h01
        |=> increment_out == RAW_W'($past(snoop_hit_in)))
        else $error("hit snoop count wrong");

    AST_SNOOP_HITE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && is_snoop && unit_mask_in == 8'h02
        |=> increment_out == RAW_W'($past(snoop_hite_in)))
        else $error("hit-exclusive snoop count wrong");

    AST_RET_NET: assert property (@(posedge clk_in)
        disable iff (rst_in)
        plain && ret_any_decoded
        && retired_instruction_count_in > retire_fault_excluded_in
        |=> increment_out == RAW_W'($past(retired_instruction_count_in)
            - $past(retire_fault_excluded_in)))
        else $error("retired count less faults wrong");

    AST_UNDECODED_ZERO: assert property (@(posedge clk_in)
        disable iff (rst_in)
        !decoded |=> increment_out == '0 && !decoded_out)
        else $error("undecoded selection gave an increment");

    COV_PORT_WEIGHTED: cover property (@(posedge clk_in) disable iff (rst_in)
        plain && uops_decoded ##1 increment_out > RAW_W'(1));

    COV_STALL_EDGE: cover property (@(posedge clk_in) disable iff (rst_in)
        active && invert_in && edge_in ##1 increment_out == RAW_W'(1));

    COV_SNOOP: cover property (@(posedge clk_in) disable iff (rst_in)
        snoop_decoded && snoop_event);

    COV_RET_FAULT: cover property (@(posedge clk_in) disable iff (rst_in)
        ret_any_decoded && retire_fault_excluded_in != '0);

endmodule

// [verilog/pes_qualifier.sv]
// Threshold, invert and edge qualifier for one counter
module pes_qualifier #(
    parameter int RAW_W = pes_pkg::RAW_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Qualifier controls
    input wire logic active_in,
    input wire logic [RAW_W-1:0] raw_in,
    input wire logic [7:0] cmask_in,
    input wire logic invert_in,
    input wire logic edge_in,
    // Per-cycle increment
    output logic [RAW_W-1:0] increment_out
);

    generate
        if (RAW_W < 1 || RAW_W > 8)
        begin : g_bad_width
            $error("pes_qualifier: RAW_W must be 1 to 8");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Condition
    // ----------------------------------------------------------------
    localparam logic [RAW_W-1:0] RST_INC_W = RAW_W'(pes_pkg::RST_INCREMENT);

    logic prev_cond;
    logic [RAW_W-1:0] next_increment;
    wire logic [7:0] raw_ext = 8'(raw_in);
    wire logic threshold_met = raw_ext >= cmask_in;
    wire logic weighted = cmask_in == 8'h00;
    // Invert flips the threshold test
    wire logic cond = active_in & (threshold_met ^ invert_in);
    wire logic rise = cond & ~prev_cond;

    assign next_increment = !active_in ? RST_INC_W :
                            weighted ? raw_in :
                            edge_in ? RAW_W'(rise) : RAW_W'(cond);

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            prev_cond <= pes_pkg::RST_PREV_COND;
            increment_out <= RST_INC_W;
        end
        else
        begin
            prev_cond <= cond;
            increment_out <= next_increment;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_THRESH_ONE_CYCLE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        active_in && cmask_in == 8'h01 && !invert_in && !edge_in
        |=> increment_out == RAW_W'($past(raw_in) != '0))
        else $error("threshold one does not count active cycles");

    AST_INVERT_STALL: assert property (@(posedge clk_in)
        disable iff (rst_in)
        active_in && cmask_in == 8'h01 && invert_in && !edge_in
        |=> increment_out == RAW_W'($past(raw_in) == '0))
        else $error("invert does not count stall cycles");

    AST_EDGE_ENTRY: assert property (@(posedge clk_in)
        disable iff (rst_in)
        (active_in && cmask_in == 8'h01 && invert_in && edge_in
         && raw_in == '0) [*2]
        |=> increment_out == '0)
        else $error("edge counted a stall that did not start");

endmodule
